/* core/dpu_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - four region base registers, numbered zero to three.
// - base holds upper address bits; low twelve bits reserved, read zero.
// - four attribute registers hold size, permission, guard; other bits reserved.
// - size is a low-order thermometer mask, 4 KB up to 16 MB.
// - code 00 denies everything; 01 gives supervisor only.
// - code 10 lets user read only; 11 allows everyone everything.
// - guarded bit set blocks speculative accesses to that region.
// - global register gives permission and guard outside all regions.
// - global register holds four enable bits; all reset to zero.
// - a region counts only while its enable bit is one.
// - reserved bits read zero and ignore writes.
// - only supervisor data accesses reach the registers; others get error.
module dpu_top
   import dpu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_super,
   input wire logic reg_instr,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   output logic reg_err,
   input wire logic chk_req,
   input wire logic [31:0] chk_addr,
   input wire logic chk_we,
   input wire logic chk_super,
   input wire logic chk_spec,
   output logic chk_ack,
   output logic chk_err,
   output logic chk_hit,
   output logic [1:0] chk_hit_idx
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [NUM_REGIONS-1:0][BASE_W-1:0] base;
      logic [NUM_REGIONS-1:0][SIZE_W-1:0] size;
      logic [NUM_REGIONS-1:0][1:0] pp;
      logic [NUM_REGIONS-1:0] guard;
      logic [NUM_REGIONS-1:0] enable;
      logic [1:0] glob_pp;
      logic glob_guard;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic chk_ack;
      logic chk_err;
      logic chk_hit;
      logic [1:0] chk_idx;
   } dpu_state_s;

   dpu_state_s st_q;
   dpu_state_s st_d;

   // ***************************************************************
   // address decode
   // ***************************************************************
   function automatic logic [3:0] decode_addr(input logic [31:0] a);
      logic [3:0] r;
      r = {KIND_NONE, 2'h0};
      if (a == ADDR_GLOBAL_ATTR)
      begin
         r = {KIND_GLOBAL, 2'h0};
      end
      for (int i = 0; i < NUM_REGIONS; i++)
      begin
         if (a == ADDR_BASE0 + ADDR_REGION_STRIDE * 32'(i))
         begin
            r = {KIND_BASE, 2'(i)};
         end
         if (a == ADDR_ATTR0 + ADDR_REGION_STRIDE * 32'(i))
         begin
            r = {KIND_ATTR, 2'(i)};
         end
      end
      return r;
   endfunction : decode_addr

   // ***************************************************************
   // region match and permission
   // ***************************************************************
   logic [NUM_REGIONS-1:0] hit_vec;
   logic any_hit;
   logic [1:0] hit_idx;
   logic [1:0] sel_pp;
   logic sel_guard;
   logic allow;

   for (genvar g = 0; g < NUM_REGIONS; g++)
   begin : g_region
      dpu_region_match u_match (
         .base(st_q.base[g]),
         .size_mask(st_q.size[g]),
         .enable(st_q.enable[g]),
         .addr(chk_addr),
         .hit(hit_vec[g])
      );
   end

   always_comb
   begin
      // overlapping regions: the lowest numbered one wins
      any_hit = 1'b0;
      hit_idx = 2'h0;
      for (int i = NUM_REGIONS - 1; i >= 0; i--)
      begin
         if (hit_vec[i])
         begin
            any_hit = 1'b1;
            hit_idx = 2'(i);
         end
      end
      sel_pp = any_hit ? st_q.pp[hit_idx] : st_q.glob_pp;
      sel_guard = any_hit ? st_q.guard[hit_idx] : st_q.glob_guard;
   end

   dpu_perm_check u_perm (
      .access_permission_code(sel_pp),
      .guarded(sel_guard),
      .is_write(chk_we),
      .is_super(chk_super),
      .is_spec(chk_spec),
      .allow(allow)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   logic [3:0] dec;
   dpu_kind_e kind;
   logic [1:0] idx;
   logic reg_ok;

   always_comb
   begin
      st_d = st_q;
      dec = decode_addr(reg_addr);
      kind = dpu_kind_e'(dec[3:2]);
      idx = dec[1:0];
      // only supervisor data accesses to a mapped word are honoured
      reg_ok = reg_super && !reg_instr && (kind != KIND_NONE);
      st_d.ack = reg_req;
      st_d.err = reg_req && !reg_ok;
      st_d.rdata = 32'h0000_0000;
      if (reg_req && reg_ok && !reg_we)
      begin
         unique case (kind)
            KIND_GLOBAL:
            begin
               for (int i = 0; i < NUM_REGIONS; i++)
               begin
                  st_d.rdata[ENABLE_MSB-i] = st_q.enable[i];
               end
               st_d.rdata[PP_LSB+:2] = st_q.glob_pp;
               st_d.rdata[GUARD_BIT] = st_q.glob_guard;
            end
            KIND_BASE:
            begin
               st_d.rdata[BASE_LSB+:BASE_W] = st_q.base[idx];
            end
            KIND_ATTR:
            begin
               st_d.rdata[SIZE_LSB+:SIZE_W] = st_q.size[idx];
               st_d.rdata[PP_LSB+:2] = st_q.pp[idx];
               st_d.rdata[GUARD_BIT] = st_q.guard[idx];
            end
            default:
            begin
               st_d.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (reg_req && reg_ok && reg_we)
      begin
         // only implemented fields are stored; reserved bits are dropped
         unique case (kind)
            KIND_GLOBAL:
            begin
               for (int i = 0; i < NUM_REGIONS; i++)
               begin
                  st_d.enable[i] = reg_wdata[ENABLE_MSB-i];
               end
               st_d.glob_pp = reg_wdata[PP_LSB+:2];
               st_d.glob_guard = reg_wdata[GUARD_BIT];
            end
            KIND_BASE:
            begin
               st_d.base[idx] = reg_wdata[BASE_LSB+:BASE_W];
            end
            KIND_ATTR:
            begin
               st_d.size[idx] = reg_wdata[SIZE_LSB+:SIZE_W];
               st_d.pp[idx] = reg_wdata[PP_LSB+:2];
               st_d.guard[idx] = reg_wdata[GUARD_BIT];
            end
            default:
            begin
               st_d.ack = reg_req;
            end
         endcase
      end
      // checked access answers one cycle later
      st_d.chk_ack = chk_req;
      st_d.chk_err = chk_req && !allow;
      st_d.chk_hit = chk_req && any_hit;
      st_d.chk_idx = chk_req ? hit_idx : 2'h0;
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_q <= '0;
         st_q.enable <= ENABLE_RESET;
         st_q.glob_pp <= PP_RESET;
         for (int i = 0; i < NUM_REGIONS; i++)
         begin
            st_q.base[i] <= BASE_RESET;
            st_q.size[i] <= SIZE_RESET;
            st_q.pp[i] <= PP_RESET;
         end
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign reg_ack = st_q.ack;
   assign reg_err = st_q.err;
   assign chk_ack = st_q.chk_ack;
   assign chk_err = st_q.chk_err;
   assign chk_hit = st_q.chk_hit;
   assign chk_hit_idx = st_q.chk_idx;

   // ***************************************************************
   // assertions
   // ***************************************************************
   a_user_reg_err:
   assert property (@(posedge sys_clk) disable iff (rst)
      reg_req && (!reg_super || reg_instr) |=> reg_ack && reg_err)
   else $error("user or instruction register access not errored");

   a_base_low_zero:
   assert property (@(posedge sys_clk) disable iff (rst)
      reg_req && !reg_we && kind == KIND_BASE |=> reg_rdata[BASE_LSB-1:0] == 12'h000)
   else $error("base reserved bits not zero");

   a_global_reserved_zero:
   assert property (@(posedge sys_clk) disable iff (rst)
      reg_req && !reg_we && reg_addr == ADDR_GLOBAL_ATTR
      |=> reg_rdata[27:12] == 16'h0000 && reg_rdata[5:0] == 6'h00 && reg_rdata[9:7] == 3'h0)
   else $error("global reserved bits not zero");

   a_enable_after_reset:
   assert property (@(posedge sys_clk)
      $fell(rst) |-> st_q.enable == 4'h0 && st_q.glob_pp == PP_NONE)
   else $error("regions not disabled after reset");

   a_disabled_no_hit:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && st_q.enable == 4'h0 |=> !chk_hit)
   else $error("hit reported with all regions disabled");

   a_pp_none_denies:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && sel_pp == PP_NONE |=> chk_ack && chk_err)
   else $error("code 00 access not denied");

   a_user_ro_write:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && sel_pp == PP_USER_RO && !chk_super && chk_we |=> chk_err)
   else $error("user write to read-only area allowed");

   a_full_access_ok:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && sel_pp == PP_USER_RW && !(sel_guard && chk_spec) |=> chk_ack && !chk_err)
   else $error("code 11 access refused");

   a_guard_blocks_spec:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && chk_spec && sel_guard |=> chk_err)
   else $error("speculative access to guarded area allowed");

   a_write_then_read:
   assert property (@(posedge sys_clk) disable iff (rst)
      reg_req && reg_we && reg_super && !reg_instr && reg_addr == ADDR_BASE0
      ##1 reg_req && !reg_we && reg_super && !reg_instr && reg_addr == ADDR_BASE0
      |=> reg_rdata[31:BASE_LSB] == $past(reg_wdata[31:BASE_LSB], 2))
   else $error("base register did not keep written value");

   a_super_only_code:
   assert property (@(posedge sys_clk) disable iff (rst)
      chk_req && sel_pp == PP_SUPER_ONLY && !chk_spec |=> chk_err == !$past(chk_super))
   else $error("code 01 decode wrong");

endmodule : dpu_top

/* core/dpu_pkg.sv */
package dpu_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int NUM_REGIONS = 4;
   localparam logic [31:0] ADDR_GLOBAL_ATTR = 32'h0000_3100;
   localparam logic [31:0] ADDR_BASE0 = 32'h0000_3180;
   localparam logic [31:0] ADDR_ATTR0 = 32'h0000_3190;
   localparam logic [31:0] ADDR_REGION_STRIDE = 32'h0000_0200;

   // ***************************************************************
   // field layout (little-endian bit numbers)
   // ***************************************************************
   localparam int BASE_LSB = 12;
   localparam int BASE_W = 20;
   localparam int SIZE_LSB = 12;
   localparam int SIZE_W = 12;
   localparam int PP_LSB = 10;
   localparam int GUARD_BIT = 6;
   localparam int ENABLE_MSB = 31;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [BASE_W-1:0] BASE_RESET = 20'h0_0000;
   localparam logic [SIZE_W-1:0] SIZE_RESET = 12'h000;
   localparam logic [1:0] PP_RESET = 2'h0;
   localparam logic [NUM_REGIONS-1:0] ENABLE_RESET = 4'h0;

   // ***************************************************************
   // permission codes
   // ***************************************************************
   localparam logic [1:0] PP_NONE = 2'h0;
   localparam logic [1:0] PP_SUPER_ONLY = 2'h1;
   localparam logic [1:0] PP_USER_RO = 2'h2;
   localparam logic [1:0] PP_USER_RW = 2'h3;

   // register decode result kinds
   typedef enum logic [1:0] {KIND_NONE, KIND_GLOBAL, KIND_BASE, KIND_ATTR} dpu_kind_e;

endpackage : dpu_pkg

/* core/dpu_region_match.sv */
`timescale 1ns/1ps
module dpu_region_match
   import dpu_pkg::*;
(
   input wire logic [BASE_W-1:0] base,
   input wire logic [SIZE_W-1:0] size_mask,
   input wire logic enable,
   input wire logic [31:0] addr,
   output logic hit
);

   // ***************************************************************
   // region compare
   // ***************************************************************
   logic [BASE_W-1:0] care;

   always_comb
   begin
      // a misaligned base acts as if rounded down: its masked bits are ignored
      care = ~{{(BASE_W-SIZE_W){1'b0}}, size_mask};
      hit = enable && ((addr[31:BASE_LSB] & care) == (base & care));
   end

endmodule : dpu_region_match

/* core/dpu_perm_check.sv */
`timescale 1ns/1ps
module dpu_perm_check
   import dpu_pkg::*;
(
   input wire logic [1:0] access_permission_code,
   input wire logic guarded,
   input wire logic is_write,
   input wire logic is_super,
   input wire logic is_spec,
   output logic allow
);

   // ***************************************************************
   // permission decode
   // ***************************************************************
   logic perm_ok;

   always_comb
   begin
      unique case (access_permission_code)
         PP_NONE: perm_ok = 1'b0;
         PP_SUPER_ONLY: perm_ok = is_super;
         PP_USER_RO: perm_ok = is_super || !is_write;
         PP_USER_RW: perm_ok = 1'b1;
      endcase
      allow = perm_ok && !(guarded && is_spec);
   end

endmodule : dpu_perm_check

/* sim/dpu_cpu_model.sv */
`timescale 1ns/1ps
// ***************************************************************
// core load/store master
// ***************************************************************
module dpu_cpu_model
(
   input wire logic sys_clk,
   output logic reg_req,
   output logic reg_we,
   output logic [31:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_super,
   output logic reg_instr,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err,
   output logic chk_req,
   output logic [31:0] chk_addr,
   output logic chk_we,
   output logic chk_super,
   output logic chk_spec,
   input wire logic chk_ack,
   input wire logic chk_err,
   input wire logic chk_hit,
   input wire logic [1:0] chk_hit_idx
);
   initial
   begin
      {reg_req, reg_we, reg_addr, reg_wdata, reg_super, reg_instr} = '0;
      {chk_req, chk_addr, chk_we, chk_super, chk_spec} = '0;
   end

   // request is a one-cycle level; holding it longer would issue a second access
   task automatic reg_acc(input logic we, input logic [31:0] addr, input logic [31:0] wdata,
      input logic sup, input logic ins, output logic [31:0] rdata, output logic [1:0] resp);
      @(negedge sys_clk);
      reg_req = 1'b1;
      reg_we = we;
      reg_addr = addr;
      reg_wdata = wdata;
      reg_super = sup;
      reg_instr = ins;
      @(negedge sys_clk);
      rdata = reg_rdata;
      resp = {reg_ack, reg_err};
      reg_req = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~wdata;
   endtask : reg_acc

   // supervisor write then read of one word on back-to-back edges; request stays high
   task automatic reg_wr_rd(input logic [31:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic [3:0] resp);
      @(negedge sys_clk);
      reg_req = 1'b1;
      reg_we = 1'b1;
      reg_addr = addr;
      reg_wdata = wdata;
      reg_super = 1'b1;
      reg_instr = 1'b0;
      @(negedge sys_clk);
      resp[3:2] = {reg_ack, reg_err};
      reg_we = 1'b0;
      reg_wdata = ~wdata;
      @(negedge sys_clk);
      rdata = reg_rdata;
      resp[1:0] = {reg_ack, reg_err};
      reg_req = 1'b0;
      reg_addr = ~addr;
   endtask : reg_wr_rd

   task automatic chk_acc(input logic [31:0] addr, input logic we, input logic sup,
      input logic spec, output logic [4:0] res);
      @(negedge sys_clk);
      chk_req = 1'b1;
      chk_addr = addr;
      chk_we = we;
      chk_super = sup;
      chk_spec = spec;
      @(negedge sys_clk);
      res = {chk_ack, chk_err, chk_hit, chk_hit_idx};
      chk_req = 1'b0;
      chk_addr = ~addr;
   endtask : chk_acc
endmodule : dpu_cpu_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import dpu_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_req, reg_we, reg_super, reg_instr, reg_ack, reg_err;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, chk_addr;
   logic chk_req, chk_we, chk_super, chk_spec, chk_ack, chk_err, chk_hit;
   logic [1:0] chk_hit_idx;
   int err_total = 0;
   int n_compared = 0;
   localparam logic [31:0] M_BASE = 32'hFFFF_F000;
   localparam logic [31:0] M_ATTR = 32'h00FF_FC40;
   localparam logic [31:0] M_GLOB = 32'hF000_0C40;

   always #10 sys_clk = ~sys_clk;

   dpu_top dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_we(reg_we),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_super(reg_super), .reg_instr(reg_instr),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err), .chk_req(chk_req),
      .chk_addr(chk_addr), .chk_we(chk_we), .chk_super(chk_super), .chk_spec(chk_spec),
      .chk_ack(chk_ack), .chk_err(chk_err), .chk_hit(chk_hit), .chk_hit_idx(chk_hit_idx));

   dpu_cpu_model cpu (.sys_clk(sys_clk), .reg_req(reg_req), .reg_we(reg_we),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_super(reg_super), .reg_instr(reg_instr),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err), .chk_req(chk_req),
      .chk_addr(chk_addr), .chk_we(chk_we), .chk_super(chk_super), .chk_spec(chk_spec),
      .chk_ack(chk_ack), .chk_err(chk_err), .chk_hit(chk_hit), .chk_hit_idx(chk_hit_idx));

   // ***************************************************************
   // compare and access helpers
   // ***************************************************************
   task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_flags(input string name, input logic [4:0] exp, input logic [4:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %b seen %b", name, exp, got);
      end
   endtask : cmp_flags

   function automatic logic [31:0] a_of(input logic [31:0] a0, input int i);
      return a0 + ADDR_REGION_STRIDE * 32'(i);
   endfunction : a_of

   // access with expected error flag; read data of a refused access must be zero
   task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] d, input logic sup,
      input logic ins, input logic ex_err, input logic [31:0] ex_rd);
      logic [31:0] rd;
      logic [1:0] rs;
      cpu.reg_acc(we, a, d, sup, ins, rd, rs);
      cmp_flags("reg response", {3'h0, 1'b1, ex_err}, {3'h0, rs});
      if (!we)
      begin
         cmp_word("reg rdata", ex_rd, rd);
      end
   endtask : acc

   task automatic ck(input logic [31:0] a, input logic we, input logic sup, input logic spec,
      input logic [4:0] ex);
      logic [4:0] res;
      cpu.chk_acc(a, we, sup, spec, res);
      cmp_flags("check result", ex, res);
   endtask : ck

   function automatic logic ok_pp(input logic [1:0] pp, input logic sup, input logic we);
      return (pp == 2'h3) || (pp == 2'h2 && (sup || !we)) || (pp == 2'h1 && sup);
   endfunction : ok_pp

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // ***************************************************************
   // tests
   // ***************************************************************
   initial
   begin
      // a hang in the handshake stops here; tests need well under 2000 cycles
      repeat (5000) @(posedge sys_clk);
      err_total++;
      end_sim();
   end

   initial
   begin
      logic [31:0] d;
      logic [3:0] r2;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      acc(1'b0, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b0, 1'b0, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         acc(1'b0, a_of(ADDR_BASE0, i), 32'h0, 1'b1, 1'b0, 1'b0, 32'h0);
         acc(1'b0, a_of(ADDR_ATTR0, i), 32'h0, 1'b1, 1'b0, 1'b0, 32'h0);
      end
      // distinct data per region so aliasing between regions shows
      for (int i = 0; i < 4; i++)
      begin
         d = 32'hFFFF_FFFF - (32'(i) << 16);
         acc(1'b1, a_of(ADDR_BASE0, i), d, 1'b1, 1'b0, 1'b0, 32'h0);
         acc(1'b1, a_of(ADDR_ATTR0, i), d, 1'b1, 1'b0, 1'b0, 32'h0);
      end
      for (int i = 0; i < 4; i++)
      begin
         d = 32'hFFFF_FFFF - (32'(i) << 16);
         acc(1'b0, a_of(ADDR_BASE0, i), 32'h0, 1'b1, 1'b0, 1'b0, d & M_BASE);
         acc(1'b0, a_of(ADDR_ATTR0, i), 32'h0, 1'b1, 1'b0, 1'b0, d & M_ATTR);
      end
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'hFFFF_FFFF, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b0, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b0, 1'b0, M_GLOB);
      // refused writes must leave the register alone, refused reads return zero
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'h0, 1'b0, 1'b0, 1'b1, 32'h0);
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0);
      acc(1'b0, ADDR_GLOBAL_ATTR, 32'h0, 1'b0, 1'b0, 1'b1, 32'h0);
      acc(1'b0, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0);
      acc(1'b0, 32'h0000_3110, 32'h0, 1'b1, 1'b0, 1'b1, 32'h0);
      acc(1'b0, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b0, 1'b0, M_GLOB);
      // all regions disabled: global permission decides every code
      for (int pp = 0; pp < 4; pp++)
      begin
         acc(1'b1, ADDR_GLOBAL_ATTR, 32'(pp) << 10, 1'b1, 1'b0, 1'b0, 32'h0);
         for (int k = 0; k < 4; k++)
         begin
            ck(32'h4000_0000, k[0], k[1], 1'b0, {1'b1, !ok_pp(2'(pp), k[1], k[0]), 3'h0});
         end
      end
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'h0000_0C40, 1'b1, 1'b0, 1'b0, 32'h0);
      ck(32'h4000_0000, 1'b0, 1'b1, 1'b1, 5'h18);
      ck(32'h4000_0000, 1'b0, 1'b1, 1'b0, 5'h10);
      // back-to-back write and read: the write must be visible on the very next access
      cpu.reg_wr_rd(ADDR_BASE0, 32'h5A5A_5A5A, d, r2);
      cmp_flags("b2b response", 5'h0A, {1'b0, r2});
      cmp_word("b2b rdata", 32'h5A5A_5000, d);
      // aligned bases; region 1 overlaps region 0
      acc(1'b1, a_of(ADDR_BASE0, 0), 32'h1000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_ATTR0, 0), 32'h000F_F400, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_BASE0, 1), 32'h1000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_ATTR0, 1), 32'h0000_0C00, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_BASE0, 2), 32'h3000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_ATTR0, 2), 32'h0000_0800, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_BASE0, 3), 32'h2000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, a_of(ADDR_ATTR0, 3), 32'h00FF_FC40, 1'b1, 1'b0, 1'b0, 32'h0);
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'h0, 1'b1, 1'b0, 1'b0, 32'h0);
      ck(32'h1000_0000, 1'b0, 1'b1, 1'b0, 5'h18);
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'hF000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      ck(32'h1000_0000, 1'b0, 1'b0, 1'b0, 5'h1C);
      ck(32'h100F_FFFC, 1'b1, 1'b1, 1'b0, 5'h14);
      ck(32'h1010_0000, 1'b0, 1'b1, 1'b0, 5'h18);
      ck(32'h20FF_FFFC, 1'b1, 1'b0, 1'b0, 5'h17);
      ck(32'h20FF_FFFC, 1'b0, 1'b1, 1'b1, 5'h1F);
      ck(32'h2100_0000, 1'b0, 1'b1, 1'b0, 5'h18);
      ck(32'h3000_0FFC, 1'b0, 1'b0, 1'b0, 5'h16);
      ck(32'h3000_0FFC, 1'b1, 1'b0, 1'b0, 5'h1E);
      ck(32'h3000_1000, 1'b0, 1'b1, 1'b0, 5'h18);
      acc(1'b1, ADDR_GLOBAL_ATTR, 32'h4000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
      ck(32'h1000_0000, 1'b1, 1'b0, 1'b0, 5'h15);
      ck(32'h1000_1000, 1'b0, 1'b1, 1'b0, 5'h18);
      end_sim();
   end
endmodule : tb_top
